// ### common/pib_regs.vh
/*
  register offsets, field positions and reset values of the peripheral interrupt bank.
  assumes a plain byte-wide register port; included once per design file.
*/
`ifndef PIB_REGS_VH
`define PIB_REGS_VH
`define PIB_ADDR_W 3
`define PIB_OFF_FLAGS_ONE 3'h0
`define PIB_OFF_FLAGS_TWO 3'h1
`define PIB_OFF_ENABLE_ONE 3'h2
`define PIB_OFF_ENABLE_TWO 3'h3
`define PIB_OFF_PRIORITY_ONE 3'h4
`define PIB_OFF_PRIORITY_TWO 3'h5
`define PIB_OFF_CONTROL 3'h6
`define PIB_RST_FLAGS 8'h00
`define PIB_RST_ENABLE 8'h00
`define PIB_RST_PRIORITY 8'hFF
`define PIB_RST_CONTROL 8'h00
`define PIB_MASK_TWO 8'hDF
`define PIB_MASK_ONE_FULL 8'hFF
`define PIB_MASK_ONE_SMALL 8'h7F
`define PIB_CTL_PRIO_MODE 0
`define PIB_CTL_GATE_HIGH 1
`define PIB_CTL_GATE_LOW 2
`define PIB_BIT_PARALLEL 7
`define PIB_BIT_CONVERTER 6
`define PIB_BIT_RECEIVE 5
`define PIB_BIT_TRANSMIT 4
`define PIB_BIT_SERIAL 3
`define PIB_BIT_CAPTURE_ONE 2
`define PIB_BIT_TIMER2_MATCH 1
`define PIB_BIT_TIMER1_OVF 0
`define PIB_BIT_OSC_FAIL 7
`define PIB_BIT_COMPARATOR 6
`define PIB_BIT_NV_WRITE 4
`define PIB_BIT_BUS_COLLISION 3
`define PIB_BIT_VOLTAGE 2
`define PIB_BIT_TIMER3_OVF 1
`define PIB_BIT_CAPTURE_TWO 0
`define PIB_MODE_CAPTURE 2'h0
`define PIB_MODE_COMPARE 2'h1
`define PIB_MODE_PWM 2'h2
`endif

// ### verilog/pib_peripheral_irq_bank.v
/*
  peripheral interrupt bank: two flag, two enable and two priority registers,
  plus a control register holding the priority mode and the global enables.
  assumes event inputs arrive as one-cycle pulses or levels from logic on clk_i;
  register port: read data valid the cycle after the read strobe.
*/
`timescale 1ns/1ps
`include "pib_regs.vh"
// What this block does
// - timer-two period match sets flags-one bit 1 until software clears it.
// - timer-one rollover sets flags-one bit 0 until software writes zero.
// - capture-two flag sets on capture or compare match, never in pulse-width mode.
// - oscillator failure with switch to internal oscillator sets flags-two bit 7.
// - comparator input change sets flags-two bit 6 until cleared.
// - nonvolatile write completion sets flags-two bit 4; zero while pending.
// - serial bus collision sets flags-two bit 3 until cleared.
// - voltage condition sets bit 2; direction chosen by the detector's select bit.
// - timer-three rollover sets flags-two bit 1 until cleared.
// - bit five of the second flag, enable, priority registers reads zero.
// - without priority mode, peripheral gate must also be set to interrupt.
// - enable-one bits follow flags-one order; one enables the source.
// - small package makes bit seven of the first registers read zero.
// - enable-two follows flags-two order, one enables, resets to zero.
// - priority bit one means high, zero low; used only in priority mode.
// - implemented priority bits reset to one.
// - flags-two resets to zero and is software readable and writable.
// - flags set regardless of enables, allowing polling.
// - priority mode gives two levels; otherwise a single legacy level.
// - in priority mode the low global enable gates low-priority requests.
module pib_peripheral_irq_bank #(
  parameter SMALL_PACKAGE = 0
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [2:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output reg [7:0] reg_rdata_o,
  input wire parallel_port_event_i,
  input wire converter_done_i,
  input wire receive_full_i,
  input wire transmit_empty_i,
  input wire serial_done_i,
  input wire capture_one_event_i,
  input wire timer_two_i_match_i,
  input wire timer_one_rollover_i,
  input wire osc_fail_event_i,
  input wire comparator_change_i,
  input wire nv_write_done_i,
  input wire bus_collision_i,
  input wire voltage_trip_i,
  input wire timer_three_rollover_i,
  input wire [1:0] capture_two_mode_i,
  input wire capture_two_capture_i,
  input wire capture_two_compare_i,
  input wire voltage_direction_select_i,
  output reg irq_high_o,
  output reg irq_low_o
);

  localparam [7:0] MASK_ONE = SMALL_PACKAGE ? `PIB_MASK_ONE_SMALL : `PIB_MASK_ONE_FULL;

  reg [7:0] periph_request_flags_one;
  reg [7:0] periph_request_flags_two;
  reg [7:0] periph_enable_one;
  reg [7:0] periph_enable_two;
  reg [7:0] periph_priority_one;
  reg [7:0] periph_priority_two;
  reg [7:0] irq_control;
  reg volt_prev;
  reg [7:0] ev_one;
  reg [7:0] ev_two;
  reg [7:0] next_rdata;
  reg volt_edge;
  reg cap_two_event;

  // one write port, one set vector: set wins over a software clear
  function [7:0] flag_next;
    input [7:0] cur;
    input [7:0] set;
    input wr;
    input [7:0] wdata;
    input [7:0] mask;
    begin
      flag_next = ((wr ? wdata : cur) | set) & mask;
    end
  endfunction

  // voltage trip level seen against its previous value
  always @* begin
    if (voltage_direction_select_i) begin
      volt_edge = voltage_trip_i & ~volt_prev;
    end else begin
      volt_edge = ~voltage_trip_i & volt_prev;
    end
  end

  always @* begin
    case (capture_two_mode_i)
      `PIB_MODE_CAPTURE: cap_two_event = capture_two_capture_i;
      `PIB_MODE_COMPARE: cap_two_event = capture_two_compare_i;
      `PIB_MODE_PWM: cap_two_event = 1'b0;
      default: cap_two_event = 1'b0;
    endcase
  end

  // events collected regardless of enables so software can poll
  always @* begin
    ev_one = 8'h00;
    ev_one[`PIB_BIT_PARALLEL] = parallel_port_event_i;
    ev_one[`PIB_BIT_CONVERTER] = converter_done_i;
    ev_one[`PIB_BIT_RECEIVE] = receive_full_i;
    ev_one[`PIB_BIT_TRANSMIT] = transmit_empty_i;
    ev_one[`PIB_BIT_SERIAL] = serial_done_i;
    ev_one[`PIB_BIT_CAPTURE_ONE] = capture_one_event_i;
    ev_one[`PIB_BIT_TIMER2_MATCH] = timer_two_i_match_i;
    ev_one[`PIB_BIT_TIMER1_OVF] = timer_one_rollover_i;
    ev_two = 8'h00;
    ev_two[`PIB_BIT_OSC_FAIL] = osc_fail_event_i;
    ev_two[`PIB_BIT_COMPARATOR] = comparator_change_i;
    ev_two[`PIB_BIT_NV_WRITE] = nv_write_done_i;
    ev_two[`PIB_BIT_BUS_COLLISION] = bus_collision_i;
    ev_two[`PIB_BIT_VOLTAGE] = volt_edge;
    ev_two[`PIB_BIT_TIMER3_OVF] = timer_three_rollover_i;
    ev_two[`PIB_BIT_CAPTURE_TWO] = cap_two_event;
  end

  always @* begin
    case (reg_addr_i)
      `PIB_OFF_FLAGS_ONE: next_rdata = periph_request_flags_one;
      `PIB_OFF_FLAGS_TWO: next_rdata = periph_request_flags_two;
      `PIB_OFF_ENABLE_ONE: next_rdata = periph_enable_one;
      `PIB_OFF_ENABLE_TWO: next_rdata = periph_enable_two;
      `PIB_OFF_PRIORITY_ONE: next_rdata = periph_priority_one;
      `PIB_OFF_PRIORITY_TWO: next_rdata = periph_priority_two;
      `PIB_OFF_CONTROL: next_rdata = irq_control;
      default: next_rdata = 8'h00;
    endcase
  end

  wire wr_f1 = reg_write_i && (reg_addr_i == `PIB_OFF_FLAGS_ONE);
  wire wr_f2 = reg_write_i && (reg_addr_i == `PIB_OFF_FLAGS_TWO);
  wire [7:0] ctl_mask = 8'h07;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      periph_request_flags_one <= `PIB_RST_FLAGS;
      periph_request_flags_two <= `PIB_RST_FLAGS;
      periph_enable_one <= `PIB_RST_ENABLE;
      periph_enable_two <= `PIB_RST_ENABLE;
      periph_priority_one <= `PIB_RST_PRIORITY & MASK_ONE;
      periph_priority_two <= `PIB_RST_PRIORITY & `PIB_MASK_TWO;
      irq_control <= `PIB_RST_CONTROL;
      volt_prev <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      volt_prev <= voltage_trip_i;
      reg_rdata_o <= reg_read_i ? next_rdata : 8'h00;
      periph_request_flags_one <= flag_next(periph_request_flags_one, ev_one, wr_f1, reg_wdata_i, MASK_ONE);
      periph_request_flags_two <= flag_next(periph_request_flags_two, ev_two, wr_f2, reg_wdata_i,
        `PIB_MASK_TWO);
      if (reg_write_i) begin
        case (reg_addr_i)
          `PIB_OFF_ENABLE_ONE: periph_enable_one <= reg_wdata_i & MASK_ONE;
          `PIB_OFF_ENABLE_TWO: periph_enable_two <= reg_wdata_i & `PIB_MASK_TWO;
          `PIB_OFF_PRIORITY_ONE: periph_priority_one <= reg_wdata_i & MASK_ONE;
          `PIB_OFF_PRIORITY_TWO: periph_priority_two <= reg_wdata_i & `PIB_MASK_TWO;
          `PIB_OFF_CONTROL: irq_control <= reg_wdata_i & ctl_mask;
          default: irq_control <= irq_control;
        endcase
      end
    end
  end

  // request routing; registered so outputs come from flip-flops
  wire [7:0] act_one = periph_request_flags_one & periph_enable_one;
  wire [7:0] act_two = periph_request_flags_two & periph_enable_two;
  wire prio_mode = irq_control[`PIB_CTL_PRIO_MODE];
  wire gate_high = irq_control[`PIB_CTL_GATE_HIGH];
  wire gate_low = irq_control[`PIB_CTL_GATE_LOW];
  wire any_act = |act_one | |act_two;
  wire any_high = |(act_one & periph_priority_one) | |(act_two & periph_priority_two);
  wire any_low = |(act_one & ~periph_priority_one) | |(act_two & ~periph_priority_two);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_high_o <= 1'b0;
      irq_low_o <= 1'b0;
    end else if (prio_mode) begin
      // peripheral sources need the low gate too only at low level
      irq_high_o <= gate_high & any_high;
      irq_low_o <= gate_high & gate_low & any_low;
    end else begin
      // legacy single level: both global and peripheral gate needed
      irq_high_o <= gate_high & gate_low & any_act;
      irq_low_o <= 1'b0;
    end
  end

endmodule

// ### verification/pib_chk.sv
/* port checker of the peripheral interrupt bank.
   assumes the one-cycle register port and event timing of the bank. */
`timescale 1ns/1ps
module pib_chk (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [2:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  input wire [7:0] reg_rdata_o,
  input wire timer_one_rollover_i,
  input wire osc_fail_event_i,
  input wire bus_collision_i,
  input wire voltage_trip_i,
  input wire voltage_direction_select_i,
  input wire irq_high_o,
  input wire irq_low_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire rd0 = reg_read_i && reg_addr_i == 3'h0;
  wire rd1 = reg_read_i && reg_addr_i == 3'h1;
  wire ctl = reg_write_i && reg_addr_i == 3'h6;
  a_rdata_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  a_hole_zero: assert property ($past(reg_read_i) && $past(reg_addr_i) == 3'h7 |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_bit5_zero: assert property ($past(reg_read_i) && $past(reg_addr_i) inside {3'h1, 3'h3, 3'h5} |-> !reg_rdata_o[5])
    else $error("bit five not zero");
  a_osc_flag: assert property (osc_fail_event_i ##2 rd1 |=> reg_rdata_o[7])
    else $error("osc fail flag missing");
  a_coll_flag: assert property (bus_collision_i ##2 rd1 |=> reg_rdata_o[3])
    else $error("collision flag missing");
  a_volt_flag: assert property (voltage_direction_select_i && $rose(voltage_trip_i) ##2 rd1 |=> reg_rdata_o[2])
    else $error("voltage flag missing");
  a_ovf_flag: assert property (timer_one_rollover_i ##4 rd0 |=> reg_rdata_o[0])
    else $error("overflow flag missing");
  a_gate_legacy: assert property (ctl && reg_wdata_i[2:0] == 3'b010 |-> ##2 !irq_high_o && !irq_low_o)
    else $error("request without peripheral gate");
  a_low_gate: assert property (ctl && reg_wdata_i[2:0] == 3'b011 |-> ##2 !irq_low_o)
    else $error("low request without low enable");
endmodule
bind pib_peripheral_irq_bank pib_chk i_pib_chk (.*);

// ### verification/pib_evt_src.sv
/* event source model: turns a request vector into event pulses one cycle later, each as long as its request.
   assumes requests come from the bench on clk_i. */
`timescale 1ns/1ps
module pib_evt_src (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [15:0] fire_i,
  output reg [15:0] evt_o
);
  // registered so every event is a clean copy of its request one cycle later, like a peripheral strobe
  always @(posedge clk_i) begin
    evt_o <= sys_rst_i ? 16'h0000 : fire_i;
  end
endmodule

// ### verification/tb_peripheral_irq_flag_enable_priority.sv
/* self-checking bench of the peripheral interrupt bank.
   assumes the event model beside it and read data one cycle after the strobe. */
`timescale 1ns/1ps
module tb_peripheral_irq_flag_enable_priority;
  logic clk_i = 0, sys_rst_i = 1, reg_write_i = 0, reg_read_i = 0, dir = 1, rd_d = 0, irq_high_o, irq_low_o;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic [1:0] mode = 2'h0;
  logic [15:0] fire = 16'h0000, ev, v;
  logic [7:0] exp_q[$];
  integer n_fail = 0, checks_done = 0, seed = 39421, i;
  logic [7:0] rst_t[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hDF, 8'h00, 8'h00};
  logic [7:0] rw_t[8] = '{8'hFF, 8'hDF, 8'hFF, 8'hDF, 8'hFF, 8'hDF, 8'h07, 8'h00};
  logic [2:0] sa[7] = '{3'h6, 3'h6, 3'h6, 3'h4, 3'h6, 3'h2, 3'h6};
  logic [7:0] sd[7] = '{8'h02, 8'h06, 8'h03, 8'h00, 8'h07, 8'h00, 8'h00};
  logic [1:0] se[7] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
  initial forever #25 clk_i = ~clk_i;
  pib_evt_src i_pib_evt_src (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .fire_i(fire), .evt_o(ev));
  pib_peripheral_irq_bank i_pib_peripheral_irq_bank (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .parallel_port_event_i(ev[15]), .converter_done_i(ev[14]),
    .receive_full_i(ev[13]), .transmit_empty_i(ev[12]), .serial_done_i(ev[11]), .capture_one_event_i(ev[10]),
    .timer_two_i_match_i(ev[9]), .timer_one_rollover_i(ev[8]), .osc_fail_event_i(ev[7]),
    .comparator_change_i(ev[6]), .nv_write_done_i(ev[4]), .bus_collision_i(ev[3]), .voltage_trip_i(ev[2]),
    .timer_three_rollover_i(ev[1]), .capture_two_mode_i(mode), .capture_two_capture_i(ev[0]),
    .capture_two_compare_i(ev[5]), .voltage_direction_select_i(dir), .irq_high_o(irq_high_o),
    .irq_low_o(irq_low_o));
  task end_sim;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // one spare cycle so edge-detected sources have settled before the read
  task pulse(input logic [15:0] p);
    fire <= p;
    @(posedge clk_i);
    fire <= 16'h0000;
    repeat (2) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    rd_d <= reg_read_i;
    if (rd_d) chk(reg_rdata_o, exp_q.pop_front());
  end
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 8; i++) rd(i[2:0], rst_t[i]);
    for (i = 0; i < 8; i++) wr(i[2:0], 8'hFF);
    for (i = 0; i < 8; i++) rd(i[2:0], rw_t[i]);
    for (i = 0; i < 7; i++) wr(i[2:0], 8'h00);
    for (i = 0; i < 16; i++) begin
      v = $random(seed) & 16'hFFDF;
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      pulse(v);
      rd(3'h1, v[7:0]);
      rd(3'h0, v[15:8]);
    end
    wr(3'h1, 8'h00);
    mode <= 2'h2;
    pulse(16'h0021);
    rd(3'h1, 8'h00);
    mode <= 2'h1;
    pulse(16'h0020);
    rd(3'h1, 8'h01);
    // falling-voltage direction: the flag follows the end of the trip pulse
    dir <= 1'b0;
    wr(3'h1, 8'h00);
    pulse(16'h0004);
    rd(3'h1, 8'h04);
    dir <= 1'b1;
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'hFF);
    wr(3'h2, 8'h02);
    pulse(16'h0200);
    for (i = 0; i < 7; i++) begin
      wr(sa[i], sd[i]);
      @(negedge clk_i);
      chk({6'h00, irq_high_o, irq_low_o}, {6'h00, se[i]});
      @(posedge clk_i);
    end
    // mid-run reset must bring back the power-on values
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(3'h4, 8'hFF);
    rd(3'h2, 8'h00);
    chk({6'h00, irq_high_o, irq_low_o}, 8'h00);
    repeat (2) @(posedge clk_i);
    if (exp_q.size() != 0) n_fail++;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_sim;
  end
endmodule
